// ---- src/sdid_decoder.sv ----
// Functional notes
// - drive enable input energises the servo ready state in every mode.
// - alarm reset clears only faults marked clearable; others stay latched.
// - in pulse/stored position modes, counter clear runs selected clear mode.
// - zero-speed hold with speed below threshold holds present position.
// - in torque and speed modes, direction invert reverses commanded rotation.
// - stored target move starts only on rising edge of move trigger.
// - six target select bits form binary index into 64 targets.
// - in speed modes torque limit applies only while its valid input is on.
// - in torque modes speed limit applies only while its valid input is on.
// - two speed source bits select the speed command source.
// - two torque source bits select the torque command source.
// - speed/position modes: switch off gives speed, on gives position.
// - speed/torque mode: switch off gives speed, on gives torque.
// - torque/position modes: switch off gives torque, on gives position.
// - non-default output functions reach a pin only when assigned, with sense.
`default_nettype none
`include "sdid_consts.svh"
module sdid_decoder
  import sdid_pkg::*;
(
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_b,
  input  wire logic [`SDID_DI_W-1:0]      i_din,
  input  wire logic [3:0]                 i_ctrl_mode,
  input  wire logic [`SDID_FAULT_W-1:0]   i_fault_set,
  input  wire logic [`SDID_FAULT_W-1:0]   i_fault_clearable,
  input  wire logic [1:0]                 i_clr_mode,
  input  wire logic                       i_speed_below_zero_thr,
  input  wire logic [`SDID_OUTF_W-1:0]    i_out_func,
  input  wire logic [`SDID_DO_W*4-1:0]    i_do_sel,
  input  wire logic [`SDID_DO_W-1:0]      i_do_active_low,
  input  wire logic [`SDID_DO_W-1:0]      i_do_assigned,
  output var  logic                       o_servo_ready,
  output var  logic [`SDID_FAULT_W-1:0]   o_fault,
  output var  logic                       o_cnt_clear,
  output var  logic [1:0]                 o_cnt_clear_mode,
  output var  logic                       o_pos_hold,
  output var  logic                       o_dir_invert,
  output var  logic                       o_move_start,
  output var  logic [5:0]                 o_target_idx,
  output var  logic                       o_trq_limit_en,
  output var  logic                       o_spd_limit_en,
  output var  logic [1:0]                 o_spd_src,
  output var  logic [1:0]                 o_trq_src,
  output var  sdid_loop_t                 o_loop,
  output var  logic [`SDID_DO_W-1:0]      o_dout
);

  //--------------------------------------------------------------------------
  // mode decode helpers
  //--------------------------------------------------------------------------
  // true where a speed loop may run
  function automatic logic f_spd_mode(input logic [3:0] m);
    f_spd_mode = (m == `SDID_MODE_S) || (m == `SDID_MODE_SZ) ||
                 (m == `SDID_MODE_PT_S) || (m == `SDID_MODE_PR_S) ||
                 (m == `SDID_MODE_S_T);
  endfunction

  // true where a torque loop may run, and in pulse position mode
  function automatic logic f_trq_mode(input logic [3:0] m);
    f_trq_mode = (m == `SDID_MODE_T) || (m == `SDID_MODE_TZ) ||
                 (m == `SDID_MODE_PT_T) || (m == `SDID_MODE_PR_T) ||
                 (m == `SDID_MODE_S_T) || (m == `SDID_MODE_PT);
  endfunction

  //--------------------------------------------------------------------------
  // input synchroniser
  //--------------------------------------------------------------------------
  logic [`SDID_DI_W-1:0] meta_q, meta_d;
  logic [`SDID_DI_W-1:0] sync_q, sync_d;
  logic [`SDID_DI_W-1:0] prev_q, prev_d;
  logic [`SDID_DI_W-1:0] rise;

  // two stages; only sync_q and prev_q feed logic
  always_comb begin
    meta_d = i_din;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign rise = sync_q & ~prev_q;

  //--------------------------------------------------------------------------
  // decoded state
  //--------------------------------------------------------------------------
  logic                     ready_q, ready_d;
  logic [`SDID_FAULT_W-1:0] fault_q, fault_d;
  logic                     clr_q, clr_d;
  logic [1:0]               clrm_q, clrm_d;
  logic                     hold_q, hold_d;
  logic                     inv_q, inv_d;
  logic                     move_q, move_d;
  logic [5:0]               idx_q, idx_d;
  logic                     tlen_q, tlen_d;
  logic                     slen_q, slen_d;
  logic [1:0]               ssrc_q, ssrc_d;
  logic [1:0]               tsrc_q, tsrc_d;
  sdid_loop_t               loop_q, loop_d;
  logic [`SDID_DO_W-1:0]    dout_q, dout_d;
  logic                     pos_mode;

  assign pos_mode = (i_ctrl_mode == `SDID_MODE_PT) || (i_ctrl_mode == `SDID_MODE_PR);

  // next values of every decoded action
  always_comb begin
    ready_d = sync_q[`SDID_DI_EN];
    // new faults win over a same-cycle reset; only clearable ones drop
    fault_d = fault_q;
    if (rise[`SDID_DI_ALARM_RESET_INPUT]) begin
      fault_d = fault_q & ~i_fault_clearable;
    end
    fault_d = fault_d | i_fault_set;
    clr_d  = pos_mode && rise[`SDID_DI_PULSE_COUNTER_CLEAR_INPUT];
    clrm_d = i_clr_mode;
    hold_d = sync_q[`SDID_DI_ZHOLD] && i_speed_below_zero_thr;
    // pulse position counts as torque only for source select; keep it out here
    inv_d  = sync_q[`SDID_DI_INV] && !pos_mode &&
             (f_spd_mode(i_ctrl_mode) || f_trq_mode(i_ctrl_mode));
    move_d = (i_ctrl_mode == `SDID_MODE_PR) && rise[`SDID_DI_TRIG];
    idx_d  = sync_q[`SDID_DI_TARGET_SELECT_BIT0 +: 6];
    tlen_d = f_spd_mode(i_ctrl_mode) && sync_q[`SDID_DI_TLV];
    slen_d = f_trq_mode(i_ctrl_mode) && !pos_mode && sync_q[`SDID_DI_SLV];
    ssrc_d = f_spd_mode(i_ctrl_mode) ? sync_q[`SDID_DI_SPD0 +: 2] : 2'h0;
    tsrc_d = f_trq_mode(i_ctrl_mode) ? sync_q[`SDID_DI_TCM0 +: 2] : 2'h0;
    case (i_ctrl_mode)
      `SDID_MODE_PT, `SDID_MODE_PR: begin
        loop_d = SDID_LOOP_POS;
      end
      `SDID_MODE_S, `SDID_MODE_SZ: begin
        loop_d = SDID_LOOP_SPD;
      end
      `SDID_MODE_T, `SDID_MODE_TZ: begin
        loop_d = SDID_LOOP_TRQ;
      end
      `SDID_MODE_PT_S, `SDID_MODE_PR_S: begin
        loop_d = sync_q[`SDID_DI_SP] ? SDID_LOOP_POS : SDID_LOOP_SPD;
      end
      `SDID_MODE_S_T: begin
        loop_d = sync_q[`SDID_DI_ST] ? SDID_LOOP_TRQ : SDID_LOOP_SPD;
      end
      `SDID_MODE_PT_T, `SDID_MODE_PR_T: begin
        loop_d = sync_q[`SDID_DI_TP] ? SDID_LOOP_POS : SDID_LOOP_TRQ;
      end
      default: begin
        loop_d = SDID_LOOP_POS;
      end
    endcase
  end

  //--------------------------------------------------------------------------
  // output function routing
  //--------------------------------------------------------------------------
  // unassigned pins idle off; the sense bit flips the level
  genvar g;
  generate
    for (g = 0; g < `SDID_DO_W; g++) begin : g_do
      always_comb begin
        dout_d[g] = i_do_assigned[g] &&
                    (i_out_func[i_do_sel[g*4 +: 4]] ^ i_do_active_low[g]);
      end
    end
  endgenerate

  // register all decoded outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ready_q <= 1'b0;
      fault_q <= '0;
      clr_q   <= 1'b0;
      clrm_q  <= 2'h0;
      hold_q  <= 1'b0;
      inv_q   <= 1'b0;
      move_q  <= 1'b0;
      idx_q   <= 6'h00;
      tlen_q  <= 1'b0;
      slen_q  <= 1'b0;
      ssrc_q  <= 2'h0;
      tsrc_q  <= 2'h0;
      loop_q  <= SDID_LOOP_POS;
      dout_q  <= '0;
    end else begin
      ready_q <= ready_d;
      fault_q <= fault_d;
      clr_q   <= clr_d;
      clrm_q  <= clrm_d;
      hold_q  <= hold_d;
      inv_q   <= inv_d;
      move_q  <= move_d;
      idx_q   <= idx_d;
      tlen_q  <= tlen_d;
      slen_q  <= slen_d;
      ssrc_q  <= ssrc_d;
      tsrc_q  <= tsrc_d;
      loop_q  <= loop_d;
      dout_q  <= dout_d;
    end
  end

  assign o_servo_ready    = ready_q;
  assign o_fault          = fault_q;
  assign o_cnt_clear      = clr_q;
  assign o_cnt_clear_mode = clrm_q;
  assign o_pos_hold       = hold_q;
  assign o_dir_invert     = inv_q;
  assign o_move_start     = move_q;
  assign o_target_idx     = idx_q;
  assign o_trq_limit_en   = tlen_q;
  assign o_spd_limit_en   = slen_q;
  assign o_spd_src        = ssrc_q;
  assign o_trq_src        = tsrc_q;
  assign o_loop           = loop_q;
  assign o_dout           = dout_q;

  //--------------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------------
  property p_ready;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      sync_q[`SDID_DI_EN] |=> o_servo_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("enable did not ready servo");

  property p_fault_keep;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      ($past(o_fault) & ~$past(i_fault_clearable) & ~o_fault) == '0;
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("non-clearable fault lost");

  property p_clr;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_cnt_clear |-> $past(pos_mode) && $past(rise[`SDID_DI_PULSE_COUNTER_CLEAR_INPUT]);
  endproperty
  a_clr: assert property (p_clr) else $error("counter clear without cause");

  property p_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_pos_hold |-> $past(i_speed_below_zero_thr);
  endproperty
  a_hold: assert property (p_hold) else $error("hold while speed high");

  property p_move_pulse;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_move_start |=> !o_move_start;
  endproperty
  a_move_pulse: assert property (p_move_pulse) else $error("move start repeated");

  property p_idx;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      ##1 o_target_idx == $past(sync_q[`SDID_DI_TARGET_SELECT_BIT0 +: 6]);
  endproperty
  a_idx: assert property (p_idx) else $error("target index mismatch");

  property p_tlim;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_trq_limit_en |-> $past(sync_q[`SDID_DI_TLV]);
  endproperty
  a_tlim: assert property (p_tlim) else $error("torque limit without valid");

  property p_slim;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_spd_limit_en |-> $past(sync_q[`SDID_DI_SLV]);
  endproperty
  a_slim: assert property (p_slim) else $error("speed limit without valid");

  property p_st;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_ctrl_mode == `SDID_MODE_S_T && sync_q[`SDID_DI_ST]) |=> o_loop == SDID_LOOP_TRQ;
  endproperty
  a_st: assert property (p_st) else $error("speed/torque switch wrong");

  property p_move_cause;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_move_start |-> $past(i_ctrl_mode == `SDID_MODE_PR) && $past(rise[`SDID_DI_TRIG]);
  endproperty
  a_move_cause: assert property (p_move_cause) else $error("stray move start");

  property p_inv;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_dir_invert |-> $past(sync_q[`SDID_DI_INV]) && !$past(pos_mode);
  endproperty
  a_inv: assert property (p_inv) else $error("invert outside speed or torque");

  property p_sp;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      ((i_ctrl_mode == `SDID_MODE_PT_S || i_ctrl_mode == `SDID_MODE_PR_S) &&
       sync_q[`SDID_DI_SP]) |=> o_loop == SDID_LOOP_POS;
  endproperty
  a_sp: assert property (p_sp) else $error("speed/position switch wrong");

  property p_tp;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      ((i_ctrl_mode == `SDID_MODE_PT_T || i_ctrl_mode == `SDID_MODE_PR_T) &&
       !sync_q[`SDID_DI_TP]) |=> o_loop == SDID_LOOP_TRQ;
  endproperty
  a_tp: assert property (p_tp) else $error("torque/position switch wrong");

endmodule // sdid_decoder
`default_nettype wire

// ---- src/sdid_consts.svh ----
`ifndef SDID_CONSTS_SVH
`define SDID_CONSTS_SVH
// mode codes on i_ctrl_mode
`define SDID_MODE_PT    4'h0
`define SDID_MODE_PR    4'h1
`define SDID_MODE_S     4'h2
`define SDID_MODE_T     4'h3
`define SDID_MODE_SZ    4'h4
`define SDID_MODE_TZ    4'h5
`define SDID_MODE_PT_S  4'h6
`define SDID_MODE_PR_S  4'h7
`define SDID_MODE_S_T   4'h8
`define SDID_MODE_PT_T  4'h9
`define SDID_MODE_PR_T  4'hA
// input bit positions in i_din
`define SDID_DI_EN      0
`define SDID_DI_ALARM_RESET_INPUT    1
`define SDID_DI_PULSE_COUNTER_CLEAR_INPUT    2
`define SDID_DI_ZHOLD   3
`define SDID_DI_INV     4
`define SDID_DI_TRIG    5
`define SDID_DI_TLV     6
`define SDID_DI_SLV     7
`define SDID_DI_TARGET_SELECT_BIT0    8
`define SDID_DI_SPD0    14
`define SDID_DI_TCM0    16
`define SDID_DI_SP      18
`define SDID_DI_ST      19
`define SDID_DI_TP      20
`define SDID_DI_W       21
`define SDID_FAULT_W    16
`define SDID_OUTF_W     16
`define SDID_DO_W       5
`endif

// ---- src/sdid_pkg.sv ----
`default_nettype none
`include "sdid_consts.svh"
package sdid_pkg;
  // active control loop
  typedef enum logic [1:0] {
    SDID_LOOP_POS = 2'b00,
    SDID_LOOP_SPD = 2'b01,
    SDID_LOOP_TRQ = 2'b10
  } sdid_loop_t;
endpackage
`default_nettype wire

// ---- sim/sdid_pin_panel.sv ----
`default_nettype none
`include "sdid_consts.svh"
// -----------------------------------------------------------------
// switch panel model: drives the raw command pins
// -----------------------------------------------------------------
module sdid_pin_panel (
  input  wire logic                  i_sys_clk,
  input  wire logic [`SDID_DI_W-1:0] i_pins,
  output var  logic [`SDID_DI_W-1:0] o_din
);
  timeunit 1ns;
  timeprecision 1ps;

  // contacts change on the edge by non-blocking update, so the design sees them one edge later
  initial o_din = '0;
  always @(posedge i_sys_clk) begin
    o_din <= i_pins;
  end
endmodule // sdid_pin_panel
`default_nettype wire

// ---- sim/tb_sdid_decoder.sv ----
`default_nettype none
`include "sdid_consts.svh"
module tb_sdid_decoder
  import sdid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // stimulus and observed signals
  // -----------------------------------------------------------------
  logic                    i_sys_clk = 1'b0;
  logic                    i_rst_b = 1'b0;
  logic [`SDID_DI_W-1:0]   pins = '0;
  logic [`SDID_DI_W-1:0]   din;
  logic [3:0]              i_ctrl_mode = `SDID_MODE_S;
  logic [15:0]             i_fault_set = '0;
  logic [15:0]             i_fault_clearable = '0;
  logic [1:0]              i_clr_mode = '0;
  logic                    i_speed_below_zero_thr = 1'b0;
  logic [15:0]             i_out_func = '0;
  logic [19:0]             i_do_sel = '0;
  logic [4:0]              i_do_active_low = '0;
  logic [4:0]              i_do_assigned = '0;
  logic                    o_servo_ready, o_cnt_clear, o_pos_hold, o_dir_invert, o_move_start;
  logic                    o_trq_limit_en, o_spd_limit_en;
  logic [15:0]             o_fault;
  logic [1:0]              o_cnt_clear_mode, o_spd_src, o_trq_src;
  logic [5:0]              o_target_idx;
  sdid_loop_t              o_loop;
  logic [4:0]              o_dout;
  int                      err_total = 0;
  int                      checked = 0;
  int                      mv_cnt = 0;
  int                      clr_cnt = 0;
  logic [3:0]              tm [6] = '{`SDID_MODE_PT_S, `SDID_MODE_PT_S, `SDID_MODE_S_T,
                                      `SDID_MODE_S_T, `SDID_MODE_PR_T, `SDID_MODE_PR_T};
  int                      tsw [6] = '{`SDID_DI_SP, `SDID_DI_SP, `SDID_DI_ST, `SDID_DI_ST,
                                       `SDID_DI_TP, `SDID_DI_TP};
  logic [1:0]              tl [6] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};

  always #4 i_sys_clk = ~i_sys_clk;

  sdid_pin_panel sdid_pin_panel_inst (.i_sys_clk(i_sys_clk), .i_pins(pins), .o_din(din));

  sdid_decoder sdid_decoder_inst (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_din(din), .i_ctrl_mode(i_ctrl_mode),
    .i_fault_set(i_fault_set), .i_fault_clearable(i_fault_clearable),
    .i_clr_mode(i_clr_mode), .i_speed_below_zero_thr(i_speed_below_zero_thr),
    .i_out_func(i_out_func), .i_do_sel(i_do_sel), .i_do_active_low(i_do_active_low),
    .i_do_assigned(i_do_assigned), .o_servo_ready(o_servo_ready), .o_fault(o_fault),
    .o_cnt_clear(o_cnt_clear), .o_cnt_clear_mode(o_cnt_clear_mode), .o_pos_hold(o_pos_hold),
    .o_dir_invert(o_dir_invert), .o_move_start(o_move_start), .o_target_idx(o_target_idx),
    .o_trq_limit_en(o_trq_limit_en), .o_spd_limit_en(o_spd_limit_en), .o_spd_src(o_spd_src),
    .o_trq_src(o_trq_src), .o_loop(o_loop), .o_dout(o_dout));

  // pulses are counted, so one edge giving two events shows as a wrong total
  always @(posedge i_sys_clk) begin
    if (o_move_start === 1'b1) mv_cnt++;
    if (o_cnt_clear === 1'b1) clr_cnt++;
  end

  // -----------------------------------------------------------------
  // access tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // pin path is panel + 2 sync + 1 reg, so six edges is well settled
  task automatic pin(input int b, input logic v);
    @(posedge i_sys_clk);
    pins[b] <= v;
    repeat (6) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic mode(input logic [3:0] m);
    @(posedge i_sys_clk);
    i_ctrl_mode <= m;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic final_report();
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    err_total++;
    final_report();
  end

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    #1;
    chk(o_servo_ready, 0); chk(o_fault, 0); chk(o_loop, 0);
    pin(`SDID_DI_EN, 1); chk(o_servo_ready, 1);
    pin(`SDID_DI_TLV, 1); chk(o_trq_limit_en, 1);
    pin(`SDID_DI_SPD0 + 1, 1); chk(o_spd_src, 2);
    pin(`SDID_DI_INV, 1); chk(o_dir_invert, 1);
    pin(`SDID_DI_SLV, 1); chk(o_spd_limit_en, 0);
    mode(`SDID_MODE_T); chk(o_trq_limit_en, 0); chk(o_spd_limit_en, 1);
    pin(`SDID_DI_TCM0 + 1, 1); chk(o_trq_src, 2);
    pin(`SDID_DI_ZHOLD, 1); chk(o_pos_hold, 0);
    @(posedge i_sys_clk);
    i_speed_below_zero_thr <= 1'b1;
    pin(`SDID_DI_ZHOLD, 1); chk(o_pos_hold, 1);
    pin(`SDID_DI_TRIG, 1); chk(mv_cnt, 0);
    pin(`SDID_DI_TRIG, 0);
    mode(`SDID_MODE_PR);
    @(posedge i_sys_clk);
    pins[13:8] <= 6'h2a;
    pin(`SDID_DI_TRIG, 1); chk(mv_cnt, 1); chk(o_target_idx, 16'h002a);
    repeat (10) @(posedge i_sys_clk);
    pin(`SDID_DI_TRIG, 0); chk(mv_cnt, 1);
    pin(`SDID_DI_TRIG, 1); chk(mv_cnt, 2);
    @(posedge i_sys_clk);
    i_clr_mode <= 2'h2;
    pin(`SDID_DI_PULSE_COUNTER_CLEAR_INPUT, 1); chk(clr_cnt, 1); chk(o_cnt_clear_mode, 2);
    pin(`SDID_DI_PULSE_COUNTER_CLEAR_INPUT, 0);
    mode(`SDID_MODE_T);
    pin(`SDID_DI_PULSE_COUNTER_CLEAR_INPUT, 1); chk(clr_cnt, 1);
    @(posedge i_sys_clk);
    i_fault_set <= 16'h00ff;
    i_fault_clearable <= 16'h000f;
    @(posedge i_sys_clk);
    i_fault_set <= 16'h0000;
    pin(`SDID_DI_ALARM_RESET_INPUT, 1); chk(o_fault, 16'h00f0);
    for (int k = 0; k < 6; k++) begin
      mode(tm[k]);
      pin(tsw[k], k % 2); chk(o_loop, tl[k]);
    end
    mode(`SDID_MODE_PT); chk(o_dir_invert, 0); chk(o_spd_limit_en, 0);
    chk(o_trq_src, 2);
    @(posedge i_sys_clk);
    i_out_func <= 16'h0008;
    i_do_sel <= 20'h0_0003;
    i_do_assigned <= 5'h01;
    mode(`SDID_MODE_T); chk(o_dout, 5'h01);
    @(posedge i_sys_clk);
    i_do_active_low <= 5'h01;
    mode(`SDID_MODE_T); chk(o_dout, 5'h00);
    @(posedge i_sys_clk);
    i_do_active_low <= 5'h00;
    i_do_assigned <= 5'h00;
    mode(`SDID_MODE_T); chk(o_dout, 5'h00);
    final_report();
  end
endmodule // tb_sdid_decoder
`default_nettype wire
